// ==== inc/s_act_pkg.sv ====
// constants for the s-interface activation and command block
package s_act_pkg;
   // command codes
   localparam logic [7:0] CMD_DEACT_REQ = 8'h01;
   localparam logic [7:0] CMD_ACT_TIMEOUT = 8'h02;
   localparam logic [7:0] CMD_ACT_REQ = 8'h03;
   localparam logic [7:0] CMD_MODE_NT_ADAPT = 8'h04;
   localparam logic [7:0] CMD_MODE_NT_FIXED = 8'h05;
   localparam logic [7:0] CMD_MODE_TE_SLAVE = 8'h06;
   localparam logic [7:0] CMD_MODE_TE_MASTER = 8'h07;
   localparam logic [7:0] CMD_FORMAT_1 = 8'h08;
   localparam logic [7:0] CMD_FORMAT_4 = 8'h0B;
   localparam logic [7:0] CMD_B_STRAIGHT = 8'h0C;
   localparam logic [7:0] CMD_B_SWAP = 8'h0D;
   localparam logic [7:0] CMD_DREQ_ONE = 8'h0E;
   localparam logic [7:0] CMD_DREQ_TWO = 8'h0F;
   localparam logic [7:0] CMD_EOM_IRQ_ON = 8'h10;
   localparam logic [7:0] CMD_EOM_IRQ_OFF = 8'h11;
   localparam logic [7:0] CMD_MF_ON = 8'h12;
   localparam logic [7:0] CMD_MF_OFF = 8'h13;
   localparam logic [7:0] CMD_FIRST_B_ON = 8'h14;
   localparam logic [7:0] CMD_FIRST_B_OFF = 8'h15;
   localparam logic [7:0] CMD_SECOND_B_ON = 8'h16;
   localparam logic [7:0] CMD_SECOND_B_OFF = 8'h17;
   localparam logic [7:0] CMD_LOOP_LINE_B1 = 8'h18;
   localparam logic [7:0] CMD_LOOP_LINE_B2 = 8'h19;
   localparam logic [7:0] CMD_LOOP_SYSTEM = 8'h1A;
   localparam logic [7:0] CMD_LOOP_CLEAR = 8'h1B;
   localparam logic [7:0] CMD_POWER_UP = 8'h20;
   localparam logic [7:0] CMD_POWER_DOWN = 8'h21;
   localparam logic [3:0] CMD_MF_WRITE_HI = 4'h3;
   // status codes
   localparam logic [7:0] ST_NO_CHANGE = 8'h00;
   localparam logic [7:0] ST_LINE_SIGNAL = 8'h02;
   localparam logic [7:0] ST_ACT_PENDING = 8'h03;
   localparam logic [7:0] ST_ACT_DONE = 8'h0C;
   localparam logic [7:0] ST_FRAME_LOSS = 8'h0E;
   localparam logic [7:0] ST_DEACTIVATED = 8'h0F;
   // line info codes driven to the transmitter
   localparam logic [2:0] INFO_0 = 3'd0;
   localparam logic [2:0] INFO_2 = 3'd2;
   localparam logic [2:0] INFO_4 = 3'd4;
   // counts
   localparam int SYNC_FRAMES = 3;
   localparam int LOSS_FRAMES = 3;
   localparam int CLK_HZ = 40000000;
   localparam int AR_WAIT_US = 2000;
   localparam int AR_WAIT_CYCLES = (AR_WAIT_US * (CLK_HZ / 1000000));
   localparam logic [7:0] ALL_ONES_BYTE = 8'hFF;
   // modes and activation states
   typedef enum logic [1:0] {mode_nt_adapt, mode_nt_fixed, mode_te_slave, mode_te_master} mode_e;
   typedef enum logic [2:0] {act_off, act_deact, act_pending, act_info2, act_active,
      act_lost} act_e;
endpackage : s_act_pkg

// ==== rtl/s_interface_activation_control.sv ====
// command interpreter, activation sequencer and channel router for the s-interface
//
// Overview of operation
// RULE_01 - power-up: analog on, deactivated, INFO 0, wake quiet
// RULE_02 - power-down at once, skip deactivation, wake re-armed
// RULE_03 - activation request starts activation; wait 2 ms
// RULE_04 - deactivation request runs orderly deactivation, network end
// RULE_05 - activation timeout forces orderly deactivation
// RULE_06 - fixed sampling disables dpll; network modes slave clocks
// RULE_07 - terminal master makes clocks, enables d access
// RULE_08 - terminal slave passes d bits, ignores requests
// RULE_09 - swap exchanges b1 and b2 both ways
// RULE_10 - disabled b channel: ones to line, rx off
// RULE_11 - d request only in terminal master, class kept
// RULE_12 - system loopback returns 2b+d, transparent when active
// RULE_13 - line loopbacks for b1, b2 independently
// RULE_14 - terminal mode sends multiframe bits as q1-q4
// RULE_15 - network mode sends s1-s4; needs multiframe enabled
// RULE_16 - after request network sends INFO 2, all zero
// RULE_17 - three good frames give sync, INFO 4, done
// RULE_18 - powered down, INFO 1 pulls wake and irq low
// RULE_19 - powered, INFO 1 reports pending, holds INFO 2; code sends INFO 0 until the activation request
// RULE_20 - three frames no violation pair: loss, INFO 2
// RULE_21 - regain gives done; INFO 0 deactivates, reports it
// RULE_22 - controller runs external activation timer itself
// RULE_23 - control command and mode byte codes
// RULE_24 - status byte codes, zero means no change
// RULE_25 - one selection per group, newest wins
// RULE_26 - reset gives adaptive, format 1, defaults, no loops
// RULE_27 - irq stays low until status read
`timescale 1ns/100ps

module s_chan_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 32
) (
   // clock and control
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_ce,
   // write side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // read side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
         $error("fifo depth must be a power of two of at least 2");
   end

   // full when pointers differ only in the wrap bit
   assign o_in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign o_out_valid = (wr_ptr != rd_ptr);
   assign push = i_ce && i_in_valid && o_in_ready;
   assign pop = i_ce && o_out_valid && i_out_ready;
   assign o_out_data = mem[rd_ptr[AW-1:0]];

   // pointers
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // storage, no reset needed
   always_ff @(posedge i_clk_sys)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= i_in_data;
   end
endmodule : s_chan_fifo

module s_interface_activation_control
   import s_act_pkg::*;
#(
   parameter int AR_WAIT = AR_WAIT_CYCLES,
   parameter int FIFO_DEPTH = 32
) (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_ce,
   // controller command and status
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd,
   input wire logic i_stat_rd,
   output logic [7:0] o_status,
   output logic o_irq_n,
   output logic o_line_wake_n,
   output logic o_ar_allowed,
   // line receiver events, one-cycle pulses
   input wire logic i_rx_info0,
   input wire logic i_rx_info1,
   input wire logic i_rx_frame_ok,
   input wire logic i_rx_frame_bad,
   input wire logic i_frame_tick,
   input wire logic i_fv_pair,
   // line control
   output logic [2:0] o_tx_info,
   output logic o_analog_on,
   output logic o_dpll_en,
   output logic o_clk_master,
   output logic o_d_access_en,
   output logic o_d_class_two,
   output logic [1:0] o_format,
   output logic o_eom_irq_en,
   output logic o_mf_en,
   output logic [3:0] o_mf_tx,
   output logic o_mf_to_terminal,
   // system side channel word in
   input wire logic i_sys_valid,
   output logic o_sys_ready,
   input wire logic [7:0] i_serial_tx_in_b1,
   input wire logic [7:0] i_serial_tx_in_b2,
   input wire logic [1:0] i_serial_tx_in_d,
   // system side channel word out
   output logic [7:0] o_serial_rx_out_b1,
   output logic [7:0] o_serial_rx_out_b2,
   output logic [1:0] o_serial_rx_out_d,
   output logic o_serial_rx_oe_b1,
   output logic o_serial_rx_oe_b2,
   // line side channel words
   input wire logic i_line_valid,
   input wire logic [7:0] i_line_b1,
   input wire logic [7:0] i_line_b2,
   input wire logic [1:0] i_line_d,
   output logic o_line_valid,
   input wire logic i_line_ready,
   output logic [7:0] o_line_b1,
   output logic [7:0] o_line_b2,
   output logic [1:0] o_line_d
);
   import s_act_pkg::*;

   localparam int WW = 18;
   act_e act;
   mode_e mode;
   logic swap, b1_on, b2_on, lb_sys, lb_l1, lb_l2, d_pending;
   logic [1:0] sync_cnt, loss_cnt;
   logic [16:0] warm_cnt;
   logic [7:0] ev_code;
   logic ev;
   logic [7:0] rx_b1, rx_b2;
   logic [1:0] rx_d;
   logic [7:0] tx_b1, tx_b2;
   logic [1:0] tx_d;
   logic take, is_nt, powered;

   initial
   begin
      if (AR_WAIT < 1 || AR_WAIT > 131071)
         $error("activation wait count out of range");
   end

   assign is_nt = (mode == mode_nt_adapt) || (mode == mode_nt_fixed);
   assign powered = (act != act_off);
   assign take = i_ce && i_cmd_valid;

   // configuration groups, newest selection wins within a group
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         mode <= mode_nt_adapt; // RULE_26
         o_format <= 2'h0;
         swap <= 1'b0;
         o_eom_irq_en <= 1'b1;
         o_mf_en <= 1'b0;
         b1_on <= 1'b0;
         b2_on <= 1'b1;
         lb_sys <= 1'b0;
         lb_l1 <= 1'b0;
         lb_l2 <= 1'b0;
         o_mf_tx <= 4'h0;
      end
      else if (take)
      begin
         if (i_cmd == CMD_MODE_NT_ADAPT) // RULE_23
            mode <= mode_nt_adapt;
         else if (i_cmd == CMD_MODE_NT_FIXED)
            mode <= mode_nt_fixed;
         else if (i_cmd == CMD_MODE_TE_SLAVE)
            mode <= mode_te_slave;
         else if (i_cmd == CMD_MODE_TE_MASTER)
            mode <= mode_te_master;
         else if (i_cmd >= CMD_FORMAT_1 && i_cmd <= CMD_FORMAT_4)
            o_format <= i_cmd[1:0];
         else if (i_cmd == CMD_B_STRAIGHT || i_cmd == CMD_B_SWAP)
            swap <= i_cmd[0]; // RULE_09
         else if (i_cmd == CMD_EOM_IRQ_ON || i_cmd == CMD_EOM_IRQ_OFF)
            o_eom_irq_en <= !i_cmd[0];
         else if (i_cmd == CMD_MF_ON || i_cmd == CMD_MF_OFF)
            o_mf_en <= !i_cmd[0]; // RULE_15
         else if (i_cmd == CMD_FIRST_B_ON || i_cmd == CMD_FIRST_B_OFF)
            b1_on <= !i_cmd[0];
         else if (i_cmd == CMD_SECOND_B_ON || i_cmd == CMD_SECOND_B_OFF)
            b2_on <= !i_cmd[0];
         else if (i_cmd == CMD_LOOP_LINE_B1)
            lb_l1 <= 1'b1; // RULE_13
         else if (i_cmd == CMD_LOOP_LINE_B2)
            lb_l2 <= 1'b1; // RULE_13
         else if (i_cmd == CMD_LOOP_SYSTEM)
            lb_sys <= 1'b1; // RULE_12
         else if (i_cmd == CMD_LOOP_CLEAR)
         begin
            lb_sys <= 1'b0;
            lb_l1 <= 1'b0;
            lb_l2 <= 1'b0;
         end
         else if (i_cmd[7:4] == CMD_MF_WRITE_HI)
            o_mf_tx <= i_cmd[3:0]; // RULE_14
      end
   end

   // d access request, accepted only as clock master
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         d_pending <= 1'b0;
         o_d_class_two <= 1'b0;
      end
      else if (i_ce)
      begin
         if (mode != mode_te_master)
            d_pending <= 1'b0; // RULE_08
         else if (i_cmd_valid && (i_cmd == CMD_DREQ_ONE || i_cmd == CMD_DREQ_TWO))
         begin
            d_pending <= 1'b1; // RULE_11
            o_d_class_two <= i_cmd[0];
         end
      end
   end

   // mode- and power-derived line controls
   assign o_dpll_en = (mode != mode_nt_fixed); // RULE_06
   assign o_clk_master = (mode == mode_te_master); // RULE_07
   assign o_d_access_en = (mode == mode_te_master) && powered; // RULE_07
   assign o_mf_to_terminal = is_nt; // RULE_15
   assign o_analog_on = powered; // RULE_01
   assign o_ar_allowed = powered && (warm_cnt == 17'd0);

   // warm-up count after power-up; requests before it are still honoured
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         warm_cnt <= '0;
      else if (i_ce)
      begin
         if (i_cmd_valid && i_cmd == CMD_POWER_UP)
            warm_cnt <= 17'(AR_WAIT); // RULE_03
         else if (warm_cnt != 17'd0)
            warm_cnt <= warm_cnt - 1'b1;
      end
   end

   // activation sequencer with its frame counters
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         act <= act_off;
         sync_cnt <= 2'd0;
         loss_cnt <= 2'd0;
         ev <= 1'b0;
         ev_code <= ST_NO_CHANGE;
      end
      else if (i_ce)
      begin
         ev <= 1'b0;
         if (i_cmd_valid && i_cmd == CMD_POWER_UP)
            act <= act_deact; // RULE_01
         else if (i_cmd_valid && i_cmd == CMD_POWER_DOWN)
            act <= act_off; // RULE_02
         else if (powered && i_cmd_valid
                  && (i_cmd == CMD_DEACT_REQ || i_cmd == CMD_ACT_TIMEOUT))
         begin
            act <= act_deact; // RULE_04 RULE_05
            ev <= 1'b1;
            ev_code <= ST_DEACTIVATED;
         end
         else if (i_cmd_valid && i_cmd == CMD_ACT_REQ
                  && (act == act_deact || act == act_pending))
         begin
            act <= act_info2; // RULE_03 RULE_16
            sync_cnt <= 2'd0;
         end
         else
         begin
            case (act)
               act_off:
                  if (i_rx_info1 && is_nt)
                  begin
                     ev <= 1'b1; // RULE_18
                     ev_code <= ST_LINE_SIGNAL;
                  end
               act_deact:
                  if (i_rx_info1 && is_nt)
                  begin
                     act <= act_pending; // RULE_19
                     ev <= 1'b1;
                     ev_code <= ST_ACT_PENDING;
                  end
               act_info2, act_lost:
                  if (act == act_lost && i_rx_info0)
                  begin
                     act <= act_deact; // RULE_21
                     ev <= 1'b1;
                     ev_code <= ST_DEACTIVATED;
                  end
                  else if (i_rx_frame_bad)
                     sync_cnt <= 2'd0;
                  else if (i_rx_frame_ok)
                  begin
                     if (sync_cnt == 2'(SYNC_FRAMES - 1))
                     begin
                        act <= act_active; // RULE_17 RULE_21
                        loss_cnt <= 2'd0;
                        sync_cnt <= 2'd0;
                        ev <= 1'b1;
                        ev_code <= ST_ACT_DONE;
                     end
                     else
                        sync_cnt <= sync_cnt + 1'b1;
                  end
               act_active:
                  if (i_fv_pair)
                     loss_cnt <= 2'd0;
                  else if (i_frame_tick)
                  begin
                     if (loss_cnt == 2'(LOSS_FRAMES - 1))
                     begin
                        act <= act_lost; // RULE_20
                        sync_cnt <= 2'd0;
                        ev <= 1'b1;
                        ev_code <= ST_FRAME_LOSS;
                     end
                     else
                        loss_cnt <= loss_cnt + 1'b1;
                  end
               default:
                  act <= act;
            endcase
         end
      end
   end

   // transmitter info follows the sequencer
   always_comb
   begin
      case (act)
         act_info2, act_lost:
            o_tx_info = INFO_2; // RULE_16 RULE_20
         act_active:
            o_tx_info = INFO_4; // RULE_17
         default:
            o_tx_info = INFO_0; // RULE_01 RULE_21
      endcase
   end

   // status code: new event beats a read in the same cycle
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         o_status <= ST_NO_CHANGE;
      else if (i_ce)
      begin
         if (ev)
            o_status <= ev_code; // RULE_24
         else if (i_stat_rd)
            o_status <= ST_NO_CHANGE; // RULE_27
      end
   end
   assign o_irq_n = (o_status == ST_NO_CHANGE); // RULE_27

   // wake output, quiet once powered, re-armed by power-down
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         o_line_wake_n <= 1'b1;
      else if (i_ce)
      begin
         if (powered || (i_cmd_valid && i_cmd == CMD_POWER_UP))
            o_line_wake_n <= 1'b1; // RULE_01
         else if (i_rx_info1 && is_nt)
            o_line_wake_n <= 1'b0; // RULE_18
      end
   end

   // latest word from the line receiver, held unswapped; the swap is applied at the system output
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         rx_b1 <= ALL_ONES_BYTE;
         rx_b2 <= ALL_ONES_BYTE;
         rx_d <= 2'h3;
      end
      else if (i_ce && i_line_valid)
      begin
         rx_b1 <= i_line_b1;
         rx_b2 <= i_line_b2;
         rx_d <= i_line_d;
      end
   end

   // toward the line: swap, line loops, disabled channels, d access, frame type
   always_comb
   begin
      tx_b1 = swap ? i_serial_tx_in_b2 : i_serial_tx_in_b1; // RULE_09
      tx_b2 = swap ? i_serial_tx_in_b1 : i_serial_tx_in_b2;
      if (lb_l1)
         tx_b1 = rx_b1; // RULE_13
      if (lb_l2)
         tx_b2 = rx_b2; // RULE_13
      if (!b1_on)
         tx_b1 = ALL_ONES_BYTE; // RULE_10
      if (!b2_on)
         tx_b2 = ALL_ONES_BYTE; // RULE_10
      // only a master arbitrates; without a request it idles with ones
      if (mode == mode_te_master && !d_pending)
         tx_d = 2'h3; // RULE_07
      else
         tx_d = i_serial_tx_in_d; // RULE_08
      if (o_tx_info != INFO_4)
      begin
         tx_b1 = 8'h00; // RULE_16
         tx_b2 = 8'h00;
         tx_d = 2'h0;
      end
   end

   // buffer between system and line; a full buffer stalls the system side
   s_chan_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .i_in_valid(i_sys_valid),
      .o_in_ready(o_sys_ready),
      .i_in_data({tx_b1, tx_b2, tx_d}),
      .o_out_valid(o_line_valid),
      .i_out_ready(i_line_ready),
      .o_out_data({o_line_b1, o_line_b2, o_line_d})
   );

   // toward the system: system loop or swapped line data, per accepted word
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         o_serial_rx_out_b1 <= ALL_ONES_BYTE;
         o_serial_rx_out_b2 <= ALL_ONES_BYTE;
         o_serial_rx_out_d <= 2'h3;
      end
      else if (i_ce && i_sys_valid && o_sys_ready)
      begin
         if (lb_sys)
         begin
            o_serial_rx_out_b1 <= i_serial_tx_in_b1; // RULE_12
            o_serial_rx_out_b2 <= i_serial_tx_in_b2;
            o_serial_rx_out_d <= i_serial_tx_in_d;
         end
         else
         begin
            o_serial_rx_out_b1 <= swap ? rx_b2 : rx_b1; // RULE_09
            o_serial_rx_out_b2 <= swap ? rx_b1 : rx_b2;
            o_serial_rx_out_d <= rx_d;
         end
      end
   end
   assign o_serial_rx_oe_b1 = b1_on; // RULE_10
   assign o_serial_rx_oe_b2 = b2_on; // RULE_10

   // checks
   a_pdn_forces_off: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_02
      i_ce && i_cmd_valid && i_cmd == CMD_POWER_DOWN |=> act == act_off && o_tx_info == INFO_0)
      else $error("power-down did not force the off state");
   a_pup_info0: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_01
      i_ce && i_cmd_valid && i_cmd == CMD_POWER_UP |=> o_tx_info == INFO_0 && o_line_wake_n)
      else $error("power-up did not leave INFO 0 with wake quiet");
   a_ar_starts_info2: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_16
      i_ce && i_cmd_valid && i_cmd == CMD_ACT_REQ && act == act_pending
      |=> o_tx_info == INFO_2)
      else $error("activation request did not start INFO 2");
   a_sync_done: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_17
      $rose(act == act_active) |=> o_status == ST_ACT_DONE || i_stat_rd || !o_irq_n)
      else $error("sync gained without activation report");
   a_info1_wake: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_18
      i_ce && act == act_off && is_nt && i_rx_info1 && !i_cmd_valid
      |=> !o_line_wake_n ##1 !o_irq_n)
      else $error("wake-up not signalled while powered down");
   a_pending_holds: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_19
      act == act_pending && !(i_cmd_valid && i_ce) |=> o_tx_info == INFO_0)
      else $error("INFO 2 sent before activation request");
   a_loss_after3: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_20
      i_ce && act == act_active && loss_cnt == 2'd2 && i_frame_tick && !i_fv_pair
      && !i_cmd_valid |=> o_tx_info == INFO_2 ##1 o_status == ST_FRAME_LOSS || i_stat_rd)
      else $error("frame loss not handled after three frames");
   a_irq_until_read: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_27
      !o_irq_n && !(i_ce && i_stat_rd) |=> !o_irq_n)
      else $error("interrupt released without a status read");
   a_slave_no_dreq: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_08
      mode == mode_te_slave |=> !d_pending)
      else $error("d request honoured outside clock master mode");
   a_b_off_ones: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE_10
      !b1_on && o_tx_info == INFO_4 |-> tx_b1 == ALL_ONES_BYTE && !o_serial_rx_oe_b1)
      else $error("disabled b1 not idled");
   c_full_activation: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      act == act_info2 ##[1:200] act == act_active);
   c_loss_regain: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      act == act_lost ##[1:200] act == act_active);
   c_fifo_full: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_sys_valid && !o_sys_ready);
endmodule : s_interface_activation_control

// ==== testbench/line_far_end.sv ====
// far-end line sink draining the line fifo, stalls on request
`timescale 1ns/100ps
module line_far_end (
   // clock and stall control
   input wire logic i_clk_sys,
   input wire logic i_stall,
   // fifo read side
   input wire logic i_valid,
   output logic o_ready,
   output int o_pops
);
   // never takes a word while stalled, so the fifo must hold it
   assign o_ready = !i_stall;
   initial o_pops = 0;
   // count words handed over at the edge
   always @(posedge i_clk_sys)
      if (i_valid && o_ready) o_pops <= o_pops + 1;
endmodule : line_far_end

// ==== testbench/s_interface_activation_control_tb_top.sv ====
// self-checking bench for the s-interface activation block
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module s_interface_activation_control_tb_top;
   import s_act_pkg::*;
   logic i_clk_sys = 0, i_reset_n = 0, i_ce = 1, i_cmd_valid = 0, i_stat_rd = 0;
   // line receiver hands a fresh word every cycle
   logic i_sys_valid = 0, i_line_valid = 1, i_line_ready, stall = 0;
   logic [7:0] i_cmd = 0, i_serial_tx_in_b1 = 8'hA5, i_serial_tx_in_b2 = 8'h5A;
   logic [7:0] i_line_b1 = 8'h3C, i_line_b2 = 8'hC3, o_status, o_line_b1, o_line_b2;
   logic [7:0] o_serial_rx_out_b1, o_serial_rx_out_b2;
   logic [1:0] i_serial_tx_in_d = 2'h1, i_line_d = 2'h2, o_format, o_serial_rx_out_d, o_line_d;
   logic [5:0] ev = 0;
   logic [3:0] o_mf_tx;
   logic [2:0] o_tx_info;
   logic o_irq_n, o_line_wake_n, o_ar_allowed, o_analog_on, o_dpll_en, o_clk_master;
   logic o_d_access_en, o_d_class_two, o_eom_irq_en, o_mf_en, o_mf_to_terminal, o_sys_ready;
   logic o_serial_rx_oe_b1, o_serial_rx_oe_b2, o_line_valid;
   wire i_rx_info0 = ev[0], i_rx_info1 = ev[1], i_rx_frame_ok = ev[2];
   wire i_rx_frame_bad = ev[3], i_frame_tick = ev[4], i_fv_pair = ev[5];
   int err_total = 0, num_checks = 0, pops, n;
   // dpll, clock master, d access, s bits per mode code 04..07
   localparam logic [3:0] MODE_EXP [4] = '{4'h9, 4'h1, 4'h8, 4'hE};
   // short warm-up count keeps the run brief
   s_interface_activation_control #(.AR_WAIT(8)) i_dut (.*);
   line_far_end i_far (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_valid(o_line_valid),
      .o_ready(i_line_ready), .o_pops(pops));
   initial
      forever #12.5 i_clk_sys = ~i_clk_sys;
   task automatic w(int k);
      repeat (k) @(negedge i_clk_sys);
   endtask : w
   // one-cycle strobes; the extra cycle lets status land
   task automatic cmd(logic [7:0] c);
      i_cmd = c;
      i_cmd_valid = 1;
      w(1);
      i_cmd_valid = 0;
      w(1);
   endtask : cmd
   task automatic pls(int k);
      ev[k] = 1;
      w(1);
      ev = 0;
      w(1);
   endtask : pls
   // one system word; caller checks while the line word stands
   task automatic xfer();
      i_sys_valid = 1;
      w(1);
      i_sys_valid = 0;
   endtask : xfer
   task automatic rd();
      i_stat_rd = 1;
      w(1);
      i_stat_rd = 0;
      w(1);
   endtask : rd
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #100000;
      err_total++;
      complete_run();
   end
   initial
   begin
      w(2);
      i_reset_n = 1;
      `CHK("status", ST_NO_CHANGE, o_status)
      `CHK("tx", INFO_0, o_tx_info)
      `CHK("dflt", 7'h68, {o_irq_n, o_dpll_en, o_serial_rx_oe_b1, o_serial_rx_oe_b2, o_mf_en, o_format})
      `CHK("eom", 1'h1, o_eom_irq_en)
      pls(1);
      `CHK("wake", 2'h0, {o_line_wake_n, o_irq_n})
      `CHK("status", ST_LINE_SIGNAL, o_status)
      rd();
      cmd(CMD_POWER_UP);
      `CHK("up", 4'hD, {o_analog_on, o_line_wake_n, o_ar_allowed, o_irq_n})
      w(12);
      `CHK("ar_ok", 1'h1, o_ar_allowed)
      pls(1);
      `CHK("pend", {ST_ACT_PENDING, INFO_0}, {o_status, o_tx_info})
      rd();
      cmd(CMD_ACT_REQ);
      `CHK("tx", INFO_2, o_tx_info)
      repeat (2) pls(2);
      `CHK("tx", INFO_2, o_tx_info)
      pls(2);
      `CHK("done", {ST_ACT_DONE, INFO_4, 1'h0}, {o_status, o_tx_info, o_irq_n})
      rd();
      `CHK("irq_n", 1'h1, o_irq_n)
      xfer();
      `CHK("word", {1'h1, 8'hFF, 8'h5A, 2'h1, 8'h3C, 8'hC3, 2'h2}, {o_line_valid, o_line_b1, o_line_b2, o_line_d, o_serial_rx_out_b1, o_serial_rx_out_b2, o_serial_rx_out_d})
      cmd(CMD_FIRST_B_ON);
      cmd(CMD_B_SWAP);
      xfer();
      `CHK("swap", {1'h1, 8'h5A, 8'hA5, 2'h1, 8'hC3, 8'h3C, 2'h2}, {o_line_valid, o_line_b1, o_line_b2, o_line_d, o_serial_rx_out_b1, o_serial_rx_out_b2, o_serial_rx_out_d})
      cmd(CMD_LOOP_LINE_B2);
      cmd(CMD_LOOP_SYSTEM);
      xfer();
      `CHK("loops", {1'h1, 8'h5A, 8'hC3, 2'h1, 8'hA5, 8'h5A, 2'h1}, {o_line_valid, o_line_b1, o_line_b2, o_line_d, o_serial_rx_out_b1, o_serial_rx_out_b2, o_serial_rx_out_d})
      $display("test activation done");
      repeat (2) pls(4);
      pls(5);
      repeat (2) pls(4);
      `CHK("tx", INFO_4, o_tx_info)
      pls(4);
      `CHK("loss", {ST_FRAME_LOSS, INFO_2}, {o_status, o_tx_info})
      rd();
      repeat (3) pls(2);
      `CHK("regain", ST_ACT_DONE, o_status)
      rd();
      repeat (3) pls(4);
      rd();
      pls(0);
      `CHK("deact", {ST_DEACTIVATED, INFO_0}, {o_status, o_tx_info})
      rd();
      // controller timer starts with the request and runs out before sync
      cmd(CMD_ACT_REQ);
      w(4);
      cmd(CMD_ACT_TIMEOUT);
      `CHK("t_out", {ST_DEACTIVATED, INFO_0}, {o_status, o_tx_info})
      rd();
      cmd(CMD_ACT_REQ);
      cmd(CMD_DEACT_REQ);
      `CHK("dr", {ST_DEACTIVATED, INFO_0}, {o_status, o_tx_info})
      rd();
      $display("test frame loss done");
      for (int m = 0; m < 4; m++)
      begin
         cmd(8'(CMD_MODE_NT_ADAPT + m));
         `CHK("mode", MODE_EXP[m], {o_dpll_en, o_clk_master, o_d_access_en, o_mf_to_terminal})
      end
      cmd(CMD_DREQ_TWO);
      `CHK("class", 1'h1, o_d_class_two)
      cmd(CMD_MODE_TE_SLAVE);
      cmd(CMD_DREQ_ONE);
      `CHK("slave", 2'h2, {o_d_class_two, o_d_access_en})
      cmd(8'h35);
      cmd(CMD_MF_ON);
      `CHK("mf", 5'h15, {o_mf_en, o_mf_tx})
      cmd(CMD_FIRST_B_ON);
      cmd(CMD_SECOND_B_OFF);
      `CHK("oe", 2'h2, {o_serial_rx_oe_b1, o_serial_rx_oe_b2})
      cmd(CMD_FORMAT_4);
      `CHK("fmt", 2'h3, o_format)
      cmd(CMD_MODE_NT_ADAPT);
      cmd(CMD_POWER_DOWN);
      pls(1);
      `CHK("pdn", 2'h0, {o_analog_on, o_line_wake_n})
      $display("test commands done");
      stall = 1;
      n = 0;
      i_sys_valid = 1;
      repeat (40)
      begin
         if (o_sys_ready === 1'h1) n++;
         w(1);
      end
      i_sys_valid = 0;
      `CHK("fill", 32, n)
      `CHK("full", 2'h1, {o_sys_ready, o_line_valid})
      stall = 0;
      w(40);
      // three words from the data test were popped earlier
      `CHK("drain", 35, pops)
      `CHK("empty", 2'h2, {o_sys_ready, o_line_valid})
      $display("test fifo done");
      complete_run();
   end
endmodule : s_interface_activation_control_tb_top
